/* File: logic/ulcs_consts.svh */
// Register offsets, field positions, reset values and bit timing for the line control block
`ifndef ULCS_CONSTS_SVH
`define ULCS_CONSTS_SVH
`define ULCS_OFS_DATA 3'h0
`define ULCS_OFS_ENABLE 3'h1
`define ULCS_OFS_IDENT 3'h2
`define ULCS_OFS_FORMAT 3'h3
`define ULCS_OFS_STATUS 3'h5
`define ULCS_OFS_MODEM 3'h6
`define ULCS_FMT_STOP 2
`define ULCS_FMT_PAR_EN 3
`define ULCS_FMT_EVEN 4
`define ULCS_FMT_STICK 5
`define ULCS_FMT_BREAK 6
`define ULCS_FMT_DIVSEL 7
`define ULCS_EN_RXDATA 0
`define ULCS_EN_HOLD 1
`define ULCS_EN_LINE 2
`define ULCS_EN_MODEM 3
`define ULCS_ID_NONE 3'h1
`define ULCS_ID_LINE 3'h6
`define ULCS_ID_RXDATA 3'h4
`define ULCS_ID_HOLD 3'h2
`define ULCS_ID_MODEM 3'h0
`define ULCS_RST_FORMAT 8'h00
`define ULCS_RST_ENABLE 4'h0
`define ULCS_RST_DIVISOR 16'h0000
`define ULCS_TX_BIT_LAST 6'h0F
`define ULCS_STOP_TICKS_1 6'h10
`define ULCS_STOP_TICKS_15 6'h18
`define ULCS_STOP_TICKS_2 6'h20
`define ULCS_RX_MID 4'h7
`define ULCS_RX_LAST 4'hF
`endif

/* File: logic/ulcs_pkg.sv */
// Types and shared parity helpers for the line control block
package ulcs_pkg;
  typedef enum logic [4:0] {
    tx_idle = 5'h01, tx_start = 5'h02, tx_data = 5'h04, tx_parity = 5'h08, tx_stop = 5'h10
  } ulcs_tx_state_type;
  typedef enum logic [5:0] {
    rx_idle = 6'h01, rx_start = 6'h02, rx_data = 6'h04, rx_parity = 6'h08, rx_stop = 6'h10, rx_wait = 6'h20
  } ulcs_rx_state_type;

  function automatic logic [7:0] ulcs_char_mask(input logic [1:0] len);
    case (len)
      2'h0: ulcs_char_mask = 8'h1F;
      2'h1: ulcs_char_mask = 8'h3F;
      2'h2: ulcs_char_mask = 8'h7F;
      default: ulcs_char_mask = 8'hFF;
    endcase
  endfunction

  function automatic logic ulcs_parity_bit(input logic [7:0] data, input logic [1:0] len,
                                           input logic even, input logic stick);
    if (stick) begin
      ulcs_parity_bit = !even;
    end else begin
      ulcs_parity_bit = even ? ^(data & ulcs_char_mask(len)) : !(^(data & ulcs_char_mask(len)));
    end
  endfunction
endpackage

/* File: logic/ulcs_tx.sv */
// Serial transmitter: start, data, optional parity and stop bits at 16 ticks per bit
`timescale 1ns/100ps
`include "ulcs_consts.svh"
module ulcs_tx (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] fmt_i,
  output logic line_o,
  output logic idle_o
);
  ulcs_pkg::ulcs_tx_state_type state_reg;
  logic [7:0] shift_reg;
  logic par_reg;
  logic [5:0] tick_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic line_reg;
  logic [2:0] last_bit;
  logic [5:0] stop_ticks;
  logic bit_end;

  assign last_bit = {1'h0, fmt_i[1:0]} + 3'h4;
  // Half stop bit is eight ticks, so 1.5 stop bits only exists for five-bit characters
  assign stop_ticks = !fmt_i[`ULCS_FMT_STOP] ? `ULCS_STOP_TICKS_1 :
                      (fmt_i[1:0] == 2'h0) ? `ULCS_STOP_TICKS_15 : `ULCS_STOP_TICKS_2;
  assign bit_end = tick_i && (tick_cnt_reg == `ULCS_TX_BIT_LAST);
  assign idle_o = (state_reg == ulcs_pkg::tx_idle);
  assign line_o = line_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ulcs_pkg::tx_idle;
      shift_reg <= 8'h00;
      par_reg <= 1'h0;
      tick_cnt_reg <= 6'h00;
      bit_cnt_reg <= 3'h0;
      line_reg <= 1'h1;
    end else begin
      if (tick_i) begin
        tick_cnt_reg <= tick_cnt_reg + 6'h01;
      end
      case (state_reg)
        ulcs_pkg::tx_idle: if (load_i) begin
          shift_reg <= data_i;
          par_reg <= ulcs_pkg::ulcs_parity_bit(data_i, fmt_i[1:0], fmt_i[`ULCS_FMT_EVEN],
                                               fmt_i[`ULCS_FMT_STICK]);
          tick_cnt_reg <= 6'h00;
          line_reg <= 1'h0;
          state_reg <= ulcs_pkg::tx_start;
        end
        ulcs_pkg::tx_start: if (bit_end) begin
          tick_cnt_reg <= 6'h00;
          bit_cnt_reg <= 3'h0;
          line_reg <= shift_reg[0];
          state_reg <= ulcs_pkg::tx_data;
        end
        ulcs_pkg::tx_data: if (bit_end) begin
          tick_cnt_reg <= 6'h00;
          if (bit_cnt_reg == last_bit) begin
            line_reg <= fmt_i[`ULCS_FMT_PAR_EN] ? par_reg : 1'h1;
            state_reg <= fmt_i[`ULCS_FMT_PAR_EN] ? ulcs_pkg::tx_parity : ulcs_pkg::tx_stop;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= shift_reg >> 1;
            line_reg <= shift_reg[1];
          end
        end
        ulcs_pkg::tx_parity: if (bit_end) begin
          tick_cnt_reg <= 6'h00;
          line_reg <= 1'h1;
          state_reg <= ulcs_pkg::tx_stop;
        end
        ulcs_pkg::tx_stop: if (tick_i && (tick_cnt_reg == stop_ticks - 6'h01)) begin
          state_reg <= ulcs_pkg::tx_idle;
        end
        default: state_reg <= ulcs_pkg::tx_idle;
      endcase
    end
  end
endmodule

/* File: logic/ulcs_rx.sv */
// Serial receiver: mid-bit sampling at 16 ticks per bit, parity, first stop bit and break check
`timescale 1ns/100ps
`include "ulcs_consts.svh"
module ulcs_rx (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic line_i,
  input wire logic [7:0] fmt_i,
  output logic done_o,
  output logic [7:0] data_o,
  output logic par_err_o,
  output logic frame_err_o,
  output logic brk_o
);
  ulcs_pkg::ulcs_rx_state_type state_reg;
  logic [3:0] tick_cnt_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic par_rx_reg;
  logic low_reg;
  logic sample;
  logic expect_par;

  assign sample = tick_i && (tick_cnt_reg == `ULCS_RX_LAST);
  assign expect_par = ulcs_pkg::ulcs_parity_bit(shift_reg, fmt_i[1:0], fmt_i[`ULCS_FMT_EVEN],
                                                fmt_i[`ULCS_FMT_STICK]);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ulcs_pkg::rx_idle;
      tick_cnt_reg <= 4'h0;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      par_rx_reg <= 1'h0;
      low_reg <= 1'h0;
      done_o <= 1'h0;
      data_o <= 8'h00;
      par_err_o <= 1'h0;
      frame_err_o <= 1'h0;
      brk_o <= 1'h0;
    end else begin
      done_o <= 1'h0;
      if (tick_i) begin
        tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
      case (state_reg)
        ulcs_pkg::rx_idle: if (tick_i && !line_i) begin
          tick_cnt_reg <= 4'h0;
          state_reg <= ulcs_pkg::rx_start;
        end
        // A start bit that is gone by mid-bit is taken as noise
        ulcs_pkg::rx_start: if (tick_i && (tick_cnt_reg == `ULCS_RX_MID)) begin
          tick_cnt_reg <= 4'h0;
          bit_cnt_reg <= 3'h0;
          shift_reg <= 8'h00;
          low_reg <= 1'h1;
          state_reg <= line_i ? ulcs_pkg::rx_idle : ulcs_pkg::rx_data;
        end
        ulcs_pkg::rx_data: if (sample) begin
          shift_reg[bit_cnt_reg] <= line_i;
          low_reg <= low_reg && !line_i;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == {1'h0, fmt_i[1:0]} + 3'h4) begin
            state_reg <= fmt_i[`ULCS_FMT_PAR_EN] ? ulcs_pkg::rx_parity : ulcs_pkg::rx_stop;
          end
        end
        ulcs_pkg::rx_parity: if (sample) begin
          par_rx_reg <= line_i;
          low_reg <= low_reg && !line_i;
          state_reg <= ulcs_pkg::rx_stop;
        end
        // Only the first stop bit is looked at; a low line then waits for idle
        ulcs_pkg::rx_stop: if (sample) begin
          done_o <= 1'h1;
          data_o <= shift_reg;
          frame_err_o <= !line_i;
          par_err_o <= fmt_i[`ULCS_FMT_PAR_EN] && (par_rx_reg != expect_par);
          brk_o <= low_reg && !line_i;
          state_reg <= line_i ? ulcs_pkg::rx_idle : ulcs_pkg::rx_wait;
        end
        ulcs_pkg::rx_wait: if (line_i) begin
          state_reg <= ulcs_pkg::rx_idle;
        end
        default: state_reg <= ulcs_pkg::rx_idle;
      endcase
    end
  end
endmodule

/* File: logic/ulcs_top.sv */
// Register front end, baud tick, interrupt priority and line status for the serial element
//
// Functional notes
// - Identity code low bits: 001 idle, 110 line, 100 rx data, 010 holding, 000 modem.
// - Line status interrupt comes from error flags, removed by reading line status.
// - Received data interrupt follows data available, removed by reading receive buffer.
// - Holding empty interrupt cleared by identity read while reported, or holding write.
// - Modem interrupt from modem line changes, removed by reading modem status.
// - Format bits 1:0 select five to eight data bits.
// - Stop bit control: one, or 1.5 for five bits, else two.
// - Receiver checks only the first stop bit.
// - Format bit 3 enables parity generation and checking after the last data bit.
// - Format bit 4 selects even parity, clear selects odd.
// - Bits 3 and 5 force parity: zero with bit 4 set, one otherwise.
// - Format bit 6 holds serial output low; transmitter keeps running.
// - Format bit 7 maps shared offsets to divisor latches; host clears it otherwise.
// - Status bit 0 set when a character lands in buffer, cleared reading it.
// - Status bit 1 flags overrun, cleared on any status read.
// - Status bit 2 flags parity mismatch, cleared on any status read.
// - Status bit 3 flags missing stop bit, cleared on any status read.
// - Status bit 4 flags line low a full character, cleared on status read.
// - Any of status bits 1 to 4 raises the line status interrupt.
// - Format register reads back as written.
// - Identity bit 0 low when pending; bits 3 to 7 read zero.
// - Each interrupt type reaches the output only when its enable bit is set.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "ulcs_consts.svh"
module ulcs_top (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_input_i,
  output logic serial_output_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic dcd_n_i,
  output logic interrupt_o
);
  logic [7:0] line_format_control_reg;
  logic [3:0] interrupt_enable_reg;
  logic [15:0] divisor_reg;
  logic [15:0] baud_cnt_reg;
  logic tick_reg;
  logic [7:0] receive_buffer_reg;
  logic rx_char_available_reg;
  logic overrun_flag_reg;
  logic rx_parity_flag_reg;
  logic rx_framing_flag_reg;
  logic rx_break_flag_reg;
  logic [7:0] transmit_holding_reg;
  logic hold_full_reg;
  logic hold_empty_pend_reg;
  logic [3:0] modem_prev_reg;
  logic [3:0] modem_delta_reg;
  logic serial_out_reg;
  logic irq_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic divsel;
  logic buf_rd;
  logic hold_wr;
  logic div_lo_wr;
  logic div_hi_wr;
  logic enable_wr;
  logic format_wr;
  logic status_rd;
  logic ident_rd;
  logic modem_rd;
  logic tx_load;
  logic tx_idle;
  logic tx_line;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_par_err;
  logic rx_frame_err;
  logic rx_brk;
  logic [3:0] modem_now;
  logic [3:0] modem_change;
  logic [3:0] pend;
  logic [2:0] ident;
  logic [7:0] line_status;

  // Priority encoder over {modem, holding, rx data, line}
  function automatic logic [2:0] ulcs_ident_code(input logic [3:0] p);
    if (p[0]) begin
      ulcs_ident_code = `ULCS_ID_LINE;
    end else if (p[1]) begin
      ulcs_ident_code = `ULCS_ID_RXDATA;
    end else if (p[2]) begin
      ulcs_ident_code = `ULCS_ID_HOLD;
    end else if (p[3]) begin
      ulcs_ident_code = `ULCS_ID_MODEM;
    end else begin
      ulcs_ident_code = `ULCS_ID_NONE;
    end
  endfunction

  function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  assign divsel = line_format_control_reg[`ULCS_FMT_DIVSEL];
  assign buf_rd = hit(rd_i, addr_i, `ULCS_OFS_DATA) && !divsel;
  assign hold_wr = hit(wr_i, addr_i, `ULCS_OFS_DATA) && !divsel;
  assign div_lo_wr = hit(wr_i, addr_i, `ULCS_OFS_DATA) && divsel;
  assign div_hi_wr = hit(wr_i, addr_i, `ULCS_OFS_ENABLE) && divsel;
  assign enable_wr = hit(wr_i, addr_i, `ULCS_OFS_ENABLE) && !divsel;
  assign format_wr = hit(wr_i, addr_i, `ULCS_OFS_FORMAT);
  assign status_rd = hit(rd_i, addr_i, `ULCS_OFS_STATUS);
  assign ident_rd = hit(rd_i, addr_i, `ULCS_OFS_IDENT);
  assign modem_rd = hit(rd_i, addr_i, `ULCS_OFS_MODEM);

  // Line format and enables; writes to the status offset are dropped
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_format_control_reg <= `ULCS_RST_FORMAT;
    end else if (format_wr) begin
      line_format_control_reg <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      interrupt_enable_reg <= `ULCS_RST_ENABLE;
    end else if (enable_wr) begin
      interrupt_enable_reg <= wdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divisor_reg <= `ULCS_RST_DIVISOR;
    end else if (div_lo_wr) begin
      divisor_reg[7:0] <= wdata_i;
    end else if (div_hi_wr) begin
      divisor_reg[15:8] <= wdata_i;
    end
  end

  // Loading either latch restarts the count so a new divisor takes hold at once
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_cnt_reg <= `ULCS_RST_DIVISOR;
      tick_reg <= 1'h0;
    end else if (div_lo_wr || div_hi_wr || divisor_reg == 16'h0000) begin
      baud_cnt_reg <= 16'h0000;
      tick_reg <= 1'h0;
    end else if (baud_cnt_reg <= 16'h0001) begin
      baud_cnt_reg <= divisor_reg;
      tick_reg <= 1'h1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      tick_reg <= 1'h0;
    end
  end

  // Transmit holding path
  assign tx_load = hold_full_reg && tx_idle;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_holding_reg <= 8'h00;
      hold_full_reg <= 1'h0;
    end else begin
      if (hold_wr) begin
        transmit_holding_reg <= wdata_i;
        hold_full_reg <= 1'h1;
      end else if (tx_load) begin
        hold_full_reg <= 1'h0;
      end
    end
  end

  // Emptying the holding register wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_empty_pend_reg <= 1'h0;
    end else if (tx_load) begin
      hold_empty_pend_reg <= 1'h1;
    end else if (hold_wr || (ident_rd && ident == `ULCS_ID_HOLD)) begin
      hold_empty_pend_reg <= 1'h0;
    end
  end

  ulcs_tx u_tx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_reg),
    .load_i(tx_load),
    .data_i(transmit_holding_reg),
    .fmt_i(line_format_control_reg),
    .line_o(tx_line),
    .idle_o(tx_idle)
  );

  // Break overrides the pin only; the shifter keeps its own timing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_out_reg <= 1'h1;
    end else begin
      serial_out_reg <= tx_line && !line_format_control_reg[`ULCS_FMT_BREAK];
    end
  end
  assign serial_output_o = serial_out_reg;

  ulcs_rx u_rx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_reg),
    .line_i(serial_input_i),
    .fmt_i(line_format_control_reg),
    .done_o(rx_done),
    .data_o(rx_data),
    .par_err_o(rx_par_err),
    .frame_err_o(rx_frame_err),
    .brk_o(rx_brk)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      receive_buffer_reg <= 8'h00;
      rx_char_available_reg <= 1'h0;
    end else if (rx_done) begin
      receive_buffer_reg <= rx_data;
      rx_char_available_reg <= 1'h1;
    end else if (buf_rd) begin
      rx_char_available_reg <= 1'h0;
    end
  end

  // Error flags: a new event beats a status read in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrun_flag_reg <= 1'h0;
      rx_parity_flag_reg <= 1'h0;
      rx_framing_flag_reg <= 1'h0;
      rx_break_flag_reg <= 1'h0;
    end else begin
      overrun_flag_reg <= (rx_done && rx_char_available_reg && !buf_rd) ||
                          (overrun_flag_reg && !status_rd);
      rx_parity_flag_reg <= (rx_done && rx_par_err) || (rx_parity_flag_reg && !status_rd);
      rx_framing_flag_reg <= (rx_done && rx_frame_err) || (rx_framing_flag_reg && !status_rd);
      rx_break_flag_reg <= (rx_done && rx_brk) || (rx_break_flag_reg && !status_rd);
    end
  end

  // Modem lines, shown inverted; ring only flags its trailing edge
  assign modem_now = ~{dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  assign modem_change = {modem_now[3] ^ modem_prev_reg[3], modem_prev_reg[2] && !modem_now[2],
                         modem_now[1:0] ^ modem_prev_reg[1:0]};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      modem_prev_reg <= 4'h0;
      modem_delta_reg <= 4'h0;
    end else begin
      modem_prev_reg <= modem_now;
      modem_delta_reg <= modem_change | (modem_rd ? 4'h0 : modem_delta_reg);
    end
  end

  // Interrupt priority
  assign pend = {interrupt_enable_reg[`ULCS_EN_MODEM] && (|modem_delta_reg),
                 interrupt_enable_reg[`ULCS_EN_HOLD] && hold_empty_pend_reg,
                 interrupt_enable_reg[`ULCS_EN_RXDATA] && rx_char_available_reg,
                 interrupt_enable_reg[`ULCS_EN_LINE] && (overrun_flag_reg || rx_parity_flag_reg ||
                 rx_framing_flag_reg || rx_break_flag_reg)};
  assign ident = ulcs_ident_code(pend);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'h0;
    end else begin
      irq_reg <= |pend;
    end
  end
  assign interrupt_o = irq_reg;

  assign line_status = {1'h0, !hold_full_reg && tx_idle, !hold_full_reg, rx_break_flag_reg,
                        rx_framing_flag_reg, rx_parity_flag_reg, overrun_flag_reg, rx_char_available_reg};

  always_comb begin
    rdata_next = 8'h00;
    case (addr_i)
      `ULCS_OFS_DATA: rdata_next = divsel ? divisor_reg[7:0] : receive_buffer_reg;
      `ULCS_OFS_ENABLE: rdata_next = divsel ? divisor_reg[15:8] : {4'h0, interrupt_enable_reg};
      `ULCS_OFS_IDENT: rdata_next = {5'h00, ident};
      `ULCS_OFS_FORMAT: rdata_next = line_format_control_reg;
      `ULCS_OFS_STATUS: rdata_next = line_status;
      `ULCS_OFS_MODEM: rdata_next = {modem_now, modem_delta_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_i ? rdata_next : 8'h00;
    end
  end
  assign rdata_o = rdata_reg;

  property p_line_first;
    @(posedge core_clk_i) disable iff (!rst_n_i) pend[0] |-> ident == `ULCS_ID_LINE;
  endproperty
  a_line_first: assert property (p_line_first) else $error("line status not reported first");

  property p_rx_over_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i) (!pend[0] && pend[1] && pend[2]) |-> ident == `ULCS_ID_RXDATA;
  endproperty
  a_rx_over_hold: assert property (p_rx_over_hold) else $error("rx data not above holding");

  property p_status_clears;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (status_rd && !rx_done) |=>
      !(overrun_flag_reg || rx_parity_flag_reg || rx_framing_flag_reg || rx_break_flag_reg);
  endproperty
  a_status_clears: assert property (p_status_clears) else $error("error flags survived status read");

  property p_char_lands;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      rx_done |=> rx_char_available_reg && receive_buffer_reg == $past(rx_data);
  endproperty
  a_char_lands: assert property (p_char_lands) else $error("received character not stored");

  property p_buf_read_clears;
    @(posedge core_clk_i) disable iff (!rst_n_i) (buf_rd && !rx_done) |=> !rx_char_available_reg;
  endproperty
  a_buf_read_clears: assert property (p_buf_read_clears) else $error("data available not cleared");

  property p_hold_write_clears;
    @(posedge core_clk_i) disable iff (!rst_n_i) (hold_wr && !tx_load) |=> !hold_empty_pend_reg;
  endproperty
  a_hold_write_clears: assert property (p_hold_write_clears) else $error("holding interrupt kept");

  property p_break_low;
    @(posedge core_clk_i) disable iff (!rst_n_i) line_format_control_reg[`ULCS_FMT_BREAK] |=> !serial_output_o;
  endproperty
  a_break_low: assert property (p_break_low) else $error("break did not hold output low");

  property p_divisor_route;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      div_lo_wr |=> divisor_reg[7:0] == $past(wdata_i) && !$changed(transmit_holding_reg);
  endproperty
  a_divisor_route: assert property (p_divisor_route) else $error("divisor write misrouted");

  property p_enable_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i) (interrupt_enable_reg == 4'h0) [*2] |-> !interrupt_o;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("interrupt with all enables clear");

  property p_ident_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      ident_rd |=> rdata_o[7:3] == 5'h00 && rdata_o[0] == ($past(pend) == 4'h0);
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identity read bits wrong");

  property p_format_read;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      hit(rd_i, addr_i, `ULCS_OFS_FORMAT) |=> rdata_o == $past(line_format_control_reg);
  endproperty
  a_format_read: assert property (p_format_read) else $error("format readback wrong");
endmodule

/* File: tb/ulcs_line_peer.sv */
// Far-side serial talker that drives the receive line of the block
`timescale 1ns/100ps
module ulcs_line_peer (
  input wire logic core_clk_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // Start bit, then n bits LSB first at 16 clocks each; the line idles high
  task automatic send(input logic [11:0] b, input int n);
    line_o <= 1'b0;
    repeat (16) @(posedge core_clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= b[i];
      repeat (16) @(posedge core_clk_i);
    end
    line_o <= 1'b1;
    // One idle clock so back-to-back frames never assign the line twice in one step
    @(posedge core_clk_i);
  endtask
endmodule

/* File: tb/test_uart_line_control_status.sv */
// Self-checking bench for the line control and status block
`timescale 1ns/100ps
module test_uart_line_control_status;
  logic core_clk_i, rst_n_i, wr_i, rd_i, sin, serial_output, irq, cts_n;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic [9:0] v;
  int err_count, checked;
  ulcs_line_peer u_peer (.core_clk_i(core_clk_i), .line_o(sin));
  ulcs_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_input_i(sin), .serial_output_o(serial_output),
    .cts_n_i(cts_n), .dsr_n_i(1'b1), .ri_n_i(1'b1), .dcd_n_i(1'b1), .interrupt_o(irq));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= x;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 x = rdata_o;
  endtask
  task automatic t_reset_values();
    rd(3'h2, d);
    chk("identity", 10'h001, {2'b0, d});
    rd(3'h3, d);
    chk("format", 10'h000, {2'b0, d});
  endtask
  task automatic t_setup();
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h1B);
    rd(3'h3, d);
    chk("format", 10'h01B, {2'b0, d});
  endtask
  task automatic t_tx_frame();
    int k;
    wr(3'h0, 8'hA5);
    k = 0;
    while (serial_output !== 1'b0 && k < 100) begin
      @(posedge core_clk_i);
      k++;
    end
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (16) @(posedge core_clk_i);
      v[i] = serial_output;
    end
    // Eight data bits, even parity of 0xA5 is zero, then the stop bit
    chk("tx frame", {2'b10, 8'hA5}, v);
  endtask
  task automatic t_rx_parity();
    wr(3'h1, 8'h05);
    u_peer.send({2'b11, 8'h5A}, 10);
    repeat (40) @(posedge core_clk_i);
    rd(3'h2, d);
    chk("identity", 10'h006, {2'b0, d});
    chk("irq", 10'h001, {9'b0, irq});
    rd(3'h5, d);
    chk("status", 10'h005, {2'b0, d & 8'h1F});
    rd(3'h2, d);
    chk("identity", 10'h004, {2'b0, d});
    rd(3'h0, d);
    chk("rx data", 10'h05A, {2'b0, d});
    rd(3'h2, d);
    chk("identity", 10'h001, {2'b0, d});
  endtask
  task automatic t_break();
    wr(3'h3, 8'h5B);
    repeat (3) @(posedge core_clk_i);
    chk("break line", 10'h000, {9'b0, serial_output});
    wr(3'h3, 8'h1B);
    repeat (3) @(posedge core_clk_i);
    chk("idle line", 10'h001, {9'b0, serial_output});
  endtask
  // Two characters unread: the second, with a low stop bit, overruns and misframes
  task automatic t_rx_errors();
    u_peer.send({2'b10, 8'hC3}, 10);
    u_peer.send({2'b00, 8'h3C}, 10);
    repeat (40) @(posedge core_clk_i);
    rd(3'h5, d);
    chk("status", 10'h00B, {2'b0, d & 8'h1F});
    rd(3'h0, d);
    chk("rx data", 10'h03C, {2'b0, d});
  endtask
  task automatic t_hold_empty();
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h3C);
    rd(3'h2, d);
    chk("identity", 10'h002, {2'b0, d});
    rd(3'h2, d);
    chk("identity", 10'h001, {2'b0, d});
  endtask
  task automatic t_modem();
    wr(3'h1, 8'h08);
    cts_n <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(3'h2, d);
    chk("identity", 10'h000, {2'b0, d});
    chk("irq", 10'h001, {9'b0, irq});
    rd(3'h6, d);
    chk("modem", 10'h011, {2'b0, d});
    rd(3'h2, d);
    chk("identity", 10'h001, {2'b0, d});
    chk("irq", 10'h000, {9'b0, irq});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #5_000_000;
    err_count++;
    print_verdict();
  end
  initial begin
    {rst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    cts_n = 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_setup();
    t_tx_frame();
    t_rx_parity();
    t_rx_errors();
    t_break();
    t_hold_empty();
    t_modem();
    print_verdict();
  end
endmodule
